// ---- design/dpop_top.sv ----
// dpll output phase offset: avalon-mm registers, ramping, masking
// assumes clk_sys is the dpll system clock; status levels arrive async
`timescale 1ns/1ps
`default_nettype none
`include "dpop_consts.svh"
module dpop_top
  import dpop_pkg::*;
#(
  parameter int RAMP_DIV = 256
)(
  input  wire logic               clk_sys,
  input  wire logic               rst_b,
  input  wire logic [8:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output logic      [31:0]        avs_readdata,
  output logic                    avs_waitrequest,
  input  wire logic               dpll_locked,
  input  wire logic               dpll_holdover,
  output logic signed [15:0]      phase_offset,
  output logic signed [31:0]      phase_shift_fs,
  output logic                    phase_inverted
);

  // bus state
  dpop_bus_state_type   st_ff, nxt_st;
  logic                 wait_ff, nxt_wait;
  logic [31:0]          rdata_ff, nxt_rdata;
  // registers
  logic [7:0]           lower_ff, nxt_lower;
  logic [7:0]           upper_ff, nxt_upper;
  logic [`DPOP_BIAS_W-1:0] bias_ff, nxt_bias;
  logic                 pbo_en_ff, nxt_pbo_en;
  logic                 ramp_dis_ff, nxt_ramp_dis;
  // ramp state
  logic signed [15:0]   cur_ff, nxt_cur;
  logic [15:0]          tick_ff, nxt_tick;
  logic signed [15:0]   off_ff, nxt_off;
  logic signed [31:0]   fs_ff, nxt_fs;
  logic                 inv_ff, nxt_inv;
  // status synchronisers
  logic [2:0]           lock_sync_ff;
  logic [2:0]           hold_sync_ff;
  logic                 lock_ff, nxt_lock;
  logic                 hold_ff, nxt_hold;

  logic signed [15:0]   target;
  logic [7:0]           idx;
  logic                 wr_go;
  logic                 rd_go;
  logic                 ramp_ok;

  function automatic logic [31:0] rd_mux(input logic [7:0] i);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (i)
      `DPOP_IDX_LOWER:   v[7:0] = lower_ff;
      `DPOP_IDX_UPPER:   v[7:0] = upper_ff;
      `DPOP_IDX_BIAS:    v[`DPOP_BIAS_W-1:0] = bias_ff;
      `DPOP_IDX_PBO_EN:  v[`DPOP_PBO_EN_BIT] = pbo_en_ff;
      `DPOP_IDX_SYNCMON: v[`DPOP_RAMP_DIS_BIT] = ramp_dis_ff;
      `DPOP_IDX_APPLIED: v[15:0] = cur_ff;
      default:           v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  assign target  = $signed({upper_ff, lower_ff});
  assign idx     = {1'b0, avs_address[8:2]};
  assign wr_go   = (st_ff == DPOP_ACK) && avs_write && avs_byteenable[0];
  assign rd_go   = (st_ff == DPOP_IDLE) && avs_read;
  // ramp only when locked outside holdover and not disabled
  assign ramp_ok = lock_ff && !hold_ff && !ramp_dis_ff;

  // bus handshake: one wait cycle, then a single ack cycle
  always_comb
  begin
    nxt_st    = st_ff;
    nxt_wait  = 1'b1;
    nxt_rdata = rdata_ff;
    unique case (st_ff)
      DPOP_IDLE:
      begin
        if (avs_read || avs_write)
        begin
          nxt_st   = DPOP_ACK;
          nxt_wait = 1'b0;
          if (rd_go)
          begin
            nxt_rdata = rd_mux(idx);
          end
        end
      end
      DPOP_ACK:
      begin
        nxt_st = DPOP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_ff    <= DPOP_IDLE;
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      st_ff    <= nxt_st;
      wait_ff  <= nxt_wait;
      rdata_ff <= nxt_rdata;
    end
  end

  // register writes take effect at the ack edge
  always_comb
  begin
    nxt_lower    = lower_ff;
    nxt_upper    = upper_ff;
    nxt_bias     = bias_ff;
    nxt_pbo_en   = pbo_en_ff;
    nxt_ramp_dis = ramp_dis_ff;
    if (wr_go)
    begin
      unique case (idx)
        `DPOP_IDX_LOWER:   nxt_lower = avs_writedata[7:0];
        `DPOP_IDX_UPPER:   nxt_upper = avs_writedata[7:0];
        `DPOP_IDX_BIAS:    nxt_bias = avs_writedata[`DPOP_BIAS_W-1:0];
        `DPOP_IDX_PBO_EN:  nxt_pbo_en = avs_writedata[`DPOP_PBO_EN_BIT];
        `DPOP_IDX_SYNCMON: nxt_ramp_dis = avs_writedata[`DPOP_RAMP_DIS_BIT];
        default:           nxt_lower = lower_ff;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lower_ff    <= `DPOP_RESET_BYTE;
      upper_ff    <= `DPOP_RESET_BYTE;
      bias_ff     <= '0;
      pbo_en_ff   <= 1'b0;
      ramp_dis_ff <= 1'b0;
    end
    else
    begin
      lower_ff    <= nxt_lower;
      upper_ff    <= nxt_upper;
      bias_ff     <= nxt_bias;
      pbo_en_ff   <= nxt_pbo_en;
      ramp_dis_ff <= nxt_ramp_dis;
    end
  end

  // status levels: accept a change once stages two and three agree
  always_comb
  begin
    nxt_lock = lock_ff;
    nxt_hold = hold_ff;
    if (lock_sync_ff[1] == lock_sync_ff[2])
    begin
      nxt_lock = lock_sync_ff[2];
    end
    if (hold_sync_ff[1] == hold_sync_ff[2])
    begin
      nxt_hold = hold_sync_ff[2];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lock_sync_ff <= 3'h0;
      hold_sync_ff <= 3'h0;
      lock_ff      <= 1'b0;
      hold_ff      <= 1'b0;
    end
    else
    begin
      lock_sync_ff <= {lock_sync_ff[1:0], dpll_locked};
      hold_sync_ff <= {hold_sync_ff[1:0], dpll_holdover};
      lock_ff      <= nxt_lock;
      hold_ff      <= nxt_hold;
    end
  end

  // applied offset, ramped one lsb per tick or jumped
  always_comb
  begin
    nxt_cur  = cur_ff;
    nxt_tick = tick_ff;
    if (!ramp_ok)
    begin
      nxt_cur  = target;
      nxt_tick = 16'h0000;
    end
    else if (cur_ff != target)
    begin
      if (tick_ff >= 16'(RAMP_DIV - 1))
      begin
        nxt_tick = 16'h0000;
        if (cur_ff < target)
        begin
          nxt_cur = cur_ff + 16'sh0001;
        end
        else
        begin
          nxt_cur = cur_ff - 16'sh0001;
        end
      end
      else
      begin
        nxt_tick = tick_ff + 16'h0001;
      end
    end
    else
    begin
      nxt_tick = 16'h0000;
    end
  end

  // outputs: offset in dpll-cycle units of 2^-11, so it tracks the
  // actual dpll period; femtosecond figure uses the nominal step
  always_comb
  begin
    nxt_off = pbo_en_ff ? `DPOP_RESET_WORD : cur_ff;
    nxt_fs  = 32'(off_ff) * $signed({18'h0, `DPOP_STEP_FS});
    nxt_inv = (off_ff == `DPOP_HALF_CYCLE);
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cur_ff  <= `DPOP_RESET_WORD;
      tick_ff <= 16'h0000;
      off_ff  <= `DPOP_RESET_WORD;
      fs_ff   <= 32'h0000_0000;
      inv_ff  <= 1'b0;
    end
    else
    begin
      cur_ff  <= nxt_cur;
      tick_ff <= nxt_tick;
      off_ff  <= nxt_off;
      fs_ff   <= nxt_fs;
      inv_ff  <= nxt_inv;
    end
  end

  assign avs_readdata    = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign phase_offset    = off_ff;
  assign phase_shift_fs  = fs_ff;
  assign phase_inverted  = inv_ff;

  a_upper_join: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    wr_go && idx == `DPOP_IDX_UPPER |=> target[15:8] == $past(avs_writedata[7:0]))
    else $error("upper byte not joined into offset");

  a_fs_scale: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    ##1 fs_ff == $past(off_ff) * 32'sd6279)
    else $error("shift not offset times step");

  a_half_inv: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    off_ff == 16'sd1024 |=> inv_ff)
    else $error("half cycle offset not inverting");

  a_ramp_step: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    ramp_ok |=> (cur_ff - $past(cur_ff)) inside {-16'sd1, 16'sd0, 16'sd1})
    else $error("ramp moved more than one step");

  a_hold_jump: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    hold_ff |=> cur_ff == $past(target))
    else $error("holdover did not apply offset directly");

  a_ramp_dis: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    ramp_dis_ff |=> cur_ff == $past(target))
    else $error("disabled ramp still ramping");

  a_pbo_mask: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    pbo_en_ff |=> off_ff == 16'sd0 ##1 fs_ff == 32'sd0)
    else $error("offset not ignored in build-out");

  a_bias_unused: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    rd_go && idx == `DPOP_IDX_BIAS |=> avs_readdata[7:6] == 2'b00 && !avs_waitrequest)
    else $error("unused bias bits not zero");

  a_wait_one: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    st_ff == DPOP_IDLE && (avs_read || avs_write) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest not one cycle low");

endmodule
`default_nettype wire

// ---- design/dpop_consts.svh ----
// constants for the dpll output phase offset block
// assumes inclusion by the block and its bench only
// How it works
// - upper and lower bytes form signed offset
// - shift equals offset times 6.279 ps
// - one step is period over 2^11
// - offset 1024 inverts the output clock
// - locked writes ramp toward new value
// - holdover applies new offset without ramping
// - control bit disables automatic ramping
// - phase build-out enabled ignores offset
// - step scales with actual dpll period; phase_shift_fs uses the fixed 6.279 ps step
// - build-out bias register resets zero, top unused
`ifndef DPOP_CONSTS_SVH
`define DPOP_CONSTS_SVH
`define DPOP_IDX_LOWER   8'h70
`define DPOP_IDX_UPPER   8'h71
`define DPOP_IDX_BIAS    8'h72
`define DPOP_IDX_PBO_EN  8'h76
`define DPOP_IDX_SYNCMON 8'h7C
`define DPOP_IDX_APPLIED 8'h7D
`define DPOP_PBO_EN_BIT  0
`define DPOP_RAMP_DIS_BIT 0
`define DPOP_BIAS_W      6
`define DPOP_STEP_FS     14'h1887
`define DPOP_FRAC_BITS   11
`define DPOP_HALF_CYCLE  16'h0400
`define DPOP_RESET_BYTE  8'h00
`define DPOP_RESET_WORD  16'h0000
`define DPOP_RAMP_DIV    16'h0100
`endif

// ---- design/dpop_pkg.sv ----
// types for the dpll output phase offset block
// assumes dpop_consts.svh holds the numeric constants
package dpop_pkg;
  typedef enum logic [0:0] {DPOP_IDLE, DPOP_ACK} dpop_bus_state_type;
endpackage

// ---- tb/tb_top.sv ----
// bench for the dpll output phase offset block
// assumes dpop_top with avalon-mm registers at byte address index*4
`timescale 1ns/1ps
`default_nettype none
`include "dpop_consts.svh"
module tb_top;
  localparam int RD = 4;
  logic               clk_sys = 1'b0;
  logic               rst_b = 1'b0;
  logic [8:0]         avs_address = '0;
  logic               avs_read = 1'b0;
  logic               avs_write = 1'b0;
  logic [31:0]        avs_writedata = '0;
  logic [3:0]         avs_byteenable = '0;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  logic               dpll_locked = 1'b0;
  logic               dpll_holdover = 1'b0;
  logic signed [15:0] phase_offset;
  logic signed [31:0] phase_shift_fs;
  logic               phase_inverted;
  logic [31:0]        exp_q[$];
  logic [7:0]         idx_l[6] = '{`DPOP_IDX_LOWER, `DPOP_IDX_UPPER, `DPOP_IDX_BIAS,
                                   `DPOP_IDX_PBO_EN, `DPOP_IDX_SYNCMON, `DPOP_IDX_APPLIED};
  logic [15:0]        v;
  int                 bad_count = 0;
  int                 n_checks = 0;

  always #2 clk_sys = ~clk_sys;

  dpop_top #(.RAMP_DIV(RD)) uut (
    .clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .dpll_locked(dpll_locked), .dpll_holdover(dpll_holdover), .phase_offset(phase_offset),
    .phase_shift_fs(phase_shift_fs), .phase_inverted(phase_inverted));

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic rd, input logic [7:0] idx, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge clk_sys);
    avs_address    <= {idx[6:0], 2'b00};
    avs_read       <= rd;
    avs_write      <= !rd;
    avs_writedata  <= d;
    avs_byteenable <= be;
    do
    begin
      @(posedge clk_sys);
    end
    while (avs_waitrequest !== 1'b0);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b0, idx, {24'h0, d}, 4'h1);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b1, idx, 32'h0, 4'hF);
  endtask

  // output ports after the pipeline has settled
  task automatic pc(input logic signed [15:0] e);
    repeat (4) @(posedge clk_sys);
    #1;
    check("phase_offset", 32'(phase_offset), 32'(e));
    check("phase_shift_fs", phase_shift_fs, 32'(e) * 32'sd6279);
    check("phase_inverted", {31'h0, phase_inverted}, {31'h0, e == 16'sh0400});
  endtask

  task automatic status(input logic lk, input logic ho);
    @(posedge clk_sys);
    dpll_locked   <= lk;
    dpll_holdover <= ho;
    repeat (8) @(posedge clk_sys);
  endtask

  // read answers compared in order of issue
  always @(posedge clk_sys)
    if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0)
      check("avs_readdata", avs_readdata, exp_q.pop_front());

  initial
  begin
    #(30000 * 4);
    bad_count++;
    end_sim();
  end

  initial
  begin
    v = 16'($urandom(32'h4f36));
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    foreach (idx_l[i])
      rd(idx_l[i], 32'h0);
    pc(16'sh0000);
    $display("test reset values done");
    wr(`DPOP_IDX_BIAS, 8'hFF);
    rd(`DPOP_IDX_BIAS, 32'h3F);
    bus(1'b0, `DPOP_IDX_BIAS, 32'h0, 4'h0);
    rd(`DPOP_IDX_BIAS, 32'h3F);
    rd(8'h10, 32'h0);
    $display("test bias register done");
    wr(`DPOP_IDX_SYNCMON, 8'h01);
    for (int i = 0; i < 5; i++)
    begin
      v = (i == 0) ? 16'h0400 : ((i == 1) ? 16'h8000 : 16'($urandom));
      wr(`DPOP_IDX_LOWER, v[7:0]);
      wr(`DPOP_IDX_UPPER, v[15:8]);
      pc(v);
      rd(`DPOP_IDX_APPLIED, {16'h0, v});
    end
    $display("test offset values done");
    wr(`DPOP_IDX_PBO_EN, 8'h01);
    pc(16'sh0000);
    rd(`DPOP_IDX_APPLIED, {16'h0, v});
    wr(`DPOP_IDX_PBO_EN, 8'h00);
    pc(v);
    $display("test build-out masking done");
    wr(`DPOP_IDX_LOWER, 8'h00);
    wr(`DPOP_IDX_UPPER, 8'h00);
    wr(`DPOP_IDX_SYNCMON, 8'h00);
    status(1'b1, 1'b0);
    wr(`DPOP_IDX_LOWER, 8'h10);
    repeat (4) @(posedge clk_sys);
    #1;
    check("ramp_midway", {31'h0, phase_offset < 16'sd16}, 32'h1);
    repeat (80) @(posedge clk_sys);
    pc(16'sh0010);
    status(1'b1, 1'b1);
    wr(`DPOP_IDX_LOWER, 8'h20);
    pc(16'sh0020);
    status(1'b1, 1'b0);
    wr(`DPOP_IDX_SYNCMON, 8'h01);
    wr(`DPOP_IDX_LOWER, 8'h05);
    pc(16'sh0005);
    $display("test ramping done");
    end_sim();
  end
endmodule
`default_nettype wire
